/* rtl/word_inc_dec_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module word_inc_dec_unit (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire word_inc_dec_pkg::req_t req_in,
   output word_inc_dec_pkg::rsp_t rsp_out
);
   // ------------------------------------------------------------
   // arithmetic
   // ------------------------------------------------------------
   word_inc_dec_pkg::pair_t inc_res;
   logic [15:0] dec_res;

   dword_incrementer u_inc (
      .src_in(req_in.data),
      .sum_out(inc_res)
   );

   word_decrementer u_dec (
      .src_in(req_in.data.lo_word),
      .diff_out(dec_res)
   );

   // ------------------------------------------------------------
   // result register
   // ------------------------------------------------------------
   word_inc_dec_pkg::rsp_t rsp_reg;
   word_inc_dec_pkg::rsp_t rsp_next;

   always_comb begin
      rsp_next = '0;
      rsp_next.data.hi_word = word_inc_dec_pkg::WORD_ZERO;
      rsp_next.data.lo_word = word_inc_dec_pkg::WORD_ZERO;
      if (req_in.valid) begin
         rsp_next.valid = 1'b1;
         // a false condition leaves the operand alone: no write, output low
         if (req_in.cond) begin
            case (req_in.op)
               word_inc_dec_pkg::OP_DINC: begin
                  rsp_next.cond_out = 1'b1;
                  rsp_next.write_en = 1'b1;
                  rsp_next.write_hi = 1'b1;
                  rsp_next.data = inc_res;
               end
               word_inc_dec_pkg::OP_DEC: begin
                  rsp_next.cond_out = 1'b1;
                  rsp_next.write_en = 1'b1;
                  rsp_next.data.lo_word = dec_res;
               end
               default: begin
                  rsp_next.cond_out = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg <= rsp_next;
      end
   end

   assign rsp_out = rsp_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_dinc_sum;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && req_in.cond && req_in.op == word_inc_dec_pkg::OP_DINC)
      |=> (rsp_out.data == $past(req_in.data) + 32'h0000_0001);
   endproperty
   a_dinc_sum: assert property (p_dinc_sum) else $error("double increment wrong");

   property p_dinc_wrap;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && req_in.cond && req_in.op == word_inc_dec_pkg::OP_DINC
       && req_in.data == 32'hFFFF_FFFF) |=> (rsp_out.data == word_inc_dec_pkg::DWORD_ZERO);
   endproperty
   a_dinc_wrap: assert property (p_dinc_wrap) else $error("increment wrap not zero");

   property p_dinc_signed;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && req_in.cond && req_in.op == word_inc_dec_pkg::OP_DINC
       && req_in.data == 32'h7FFF_FFFF) |=> (rsp_out.data == 32'h8000_0000);
   endproperty
   a_dinc_signed: assert property (p_dinc_signed) else $error("signed increment clamped");

   property p_carry;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && req_in.cond && req_in.op == word_inc_dec_pkg::OP_DINC
       && req_in.data.lo_word == 16'hFFFF)
      |=> (rsp_out.data.hi_word == $past(req_in.data.hi_word) + 16'h0001);
   endproperty
   a_carry: assert property (p_carry) else $error("carry not into high word");

   property p_off;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && !req_in.cond) |=> (!rsp_out.write_en && !rsp_out.cond_out);
   endproperty
   a_off: assert property (p_off) else $error("false condition acted");

   property p_on;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && req_in.cond
       && (req_in.op == word_inc_dec_pkg::OP_DINC || req_in.op == word_inc_dec_pkg::OP_DEC))
      |=> (rsp_out.cond_out && rsp_out.write_en && rsp_out.valid);
   endproperty
   a_on: assert property (p_on) else $error("output not on after execution");

   // an undecoded operation code must not count as an execution
   property p_bad_op;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && req_in.cond && req_in.op != word_inc_dec_pkg::OP_DINC
       && req_in.op != word_inc_dec_pkg::OP_DEC)
      |=> (rsp_out.valid && !rsp_out.write_en && !rsp_out.cond_out);
   endproperty
   a_bad_op: assert property (p_bad_op) else $error("unknown op executed");

   property p_off_data;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && !req_in.cond)
      |=> (rsp_out.valid && !rsp_out.write_hi && rsp_out.data == word_inc_dec_pkg::DWORD_ZERO);
   endproperty
   a_off_data: assert property (p_off_data) else $error("false condition left data");

   // answer stands one cycle only, so an idle cycle leaves nothing to write
   property p_idle;
      @(posedge core_clk_in) disable iff (rst_in)
      !req_in.valid |=> (!rsp_out.valid && !rsp_out.write_en && !rsp_out.cond_out);
   endproperty
   a_idle: assert property (p_idle) else $error("answer without request");

   property p_dec_hi;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && req_in.cond && req_in.op == word_inc_dec_pkg::OP_DEC)
      |=> (rsp_out.data.hi_word == word_inc_dec_pkg::WORD_ZERO);
   endproperty
   a_dec_hi: assert property (p_dec_hi) else $error("decrement touched high word");

   property p_dec;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && req_in.cond && req_in.op == word_inc_dec_pkg::OP_DEC)
      |=> (rsp_out.data.lo_word == $past(req_in.data.lo_word) - 16'h0001
           && !rsp_out.write_hi);
   endproperty
   a_dec: assert property (p_dec) else $error("decrement wrong");

   property p_dec_wrap;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && req_in.cond && req_in.op == word_inc_dec_pkg::OP_DEC
       && req_in.data.lo_word == word_inc_dec_pkg::WORD_ZERO)
      |=> (rsp_out.data.lo_word == word_inc_dec_pkg::WORD_MAX);
   endproperty
   a_dec_wrap: assert property (p_dec_wrap) else $error("decrement wrap not max");

   property p_dec_signed;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && req_in.cond && req_in.op == word_inc_dec_pkg::OP_DEC
       && req_in.data.lo_word == 16'h8000) |=> (rsp_out.data.lo_word == 16'h7FFF);
   endproperty
   a_dec_signed: assert property (p_dec_signed) else $error("signed decrement clamped");

   property p_pair_back;
      @(posedge core_clk_in) disable iff (rst_in)
      (req_in.valid && req_in.cond && req_in.op == word_inc_dec_pkg::OP_DINC)
      |=> (rsp_out.write_hi && rsp_out.write_en);
   endproperty
   a_pair_back: assert property (p_pair_back) else $error("pair not written back");
endmodule : word_inc_dec_unit
`default_nettype wire

/* rtl/word_inc_dec_pkg.sv */
// Overview of operation
// - double increment adds one to register pair
// - double increment operand unsigned 32-bit, max 4294967295
// - increment past maximum wraps pair to zero
// - signed view: 2147483647 plus one gives -2147483648
// - false condition: operand kept, output false
// - executing instruction drives its output true
// - single decrement subtracts one from 16-bit register
// - single decrement operand unsigned 16-bit, max 65535
// - decrement below zero wraps to 65535
// - signed view: -32768 minus one gives 32767
// - double result written back to source pair
package word_inc_dec_pkg;
   localparam int WORD_W = 16;
   localparam int DWORD_W = 32;
   localparam int CNT_DEC_STEP = 1;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [31:0] DWORD_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      OP_NONE,
      OP_DINC,
      OP_DEC
   } op_t;

   // operand as handed over by the sequencer: high register, low register
   typedef struct packed {
      logic [15:0] hi_word;
      logic [15:0] lo_word;
   } pair_t;

   typedef struct packed {
      logic valid;
      logic cond;
      op_t op;
      pair_t data;
   } req_t;

   typedef struct packed {
      logic valid;
      logic cond_out;
      logic write_en;
      logic write_hi;
      pair_t data;
   } rsp_t;
endpackage : word_inc_dec_pkg

/* rtl/dword_incrementer.sv */
`timescale 1ns/1ps
`default_nettype none
module dword_incrementer (
   input wire word_inc_dec_pkg::pair_t src_in,
   output word_inc_dec_pkg::pair_t sum_out
);
   logic [16:0] lo_sum;
   logic carry;
   // plain binary carry, no clamping at either signed or unsigned limit
   always_comb begin
      lo_sum = {1'b0, src_in.lo_word} + 17'h00001;
      carry = lo_sum[16];
      sum_out.lo_word = lo_sum[15:0];
      sum_out.hi_word = src_in.hi_word + {15'h0000, carry};
   end
endmodule : dword_incrementer
`default_nettype wire

/* rtl/word_decrementer.sv */
`timescale 1ns/1ps
`default_nettype none
module word_decrementer (
   input wire logic [15:0] src_in,
   output logic [15:0] diff_out
);
   // borrow out of bit 15 is dropped, so zero wraps to the maximum
   always_comb begin
      diff_out = src_in - 16'h0001;
   end
endmodule : word_decrementer
`default_nettype wire

/* sim/operand_store.sv */
`timescale 1ns/1ps
`default_nettype none
module operand_store (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic go_in,
   input wire logic cond_in,
   input wire word_inc_dec_pkg::op_t op_in,
   input wire logic load_in,
   input wire logic [31:0] load_val_in,
   input wire word_inc_dec_pkg::rsp_t rsp_in,
   output word_inc_dec_pkg::req_t req_out,
   output logic [31:0] regs_out,
   output logic seen_out
);
   // ----------------------------------------
   // sequencer: register pair A+1, A
   // ----------------------------------------
   // idle operand lines carry the inverse so a stale value is never mistaken for live data
   always_comb begin
      req_out.valid = go_in;
      req_out.cond = cond_in;
      req_out.op = op_in;
      req_out.data = go_in ? regs_out : ~regs_out;
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         seen_out <= 1'b0;
      end else if (load_in) begin
         regs_out <= load_val_in;
      end else if (rsp_in.valid) begin
         seen_out <= rsp_in.cond_out;
         if (rsp_in.write_en) begin
            regs_out[15:0] <= rsp_in.data.lo_word;
            if (rsp_in.write_hi) begin
               regs_out[31:16] <= rsp_in.data.hi_word;
            end
         end
      end
   end
endmodule : operand_store
`default_nettype wire

/* sim/word_inc_dec_unit_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module word_inc_dec_unit_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic cond = 1'b0;
   logic load = 1'b0;
   logic seen;
   logic [31:0] load_val = 32'h0000_0000;
   logic [31:0] regs;
   word_inc_dec_pkg::op_t op = word_inc_dec_pkg::OP_NONE;
   word_inc_dec_pkg::req_t req;
   word_inc_dec_pkg::rsp_t rsp;
   int err_total = 0;
   int checks_done = 0;
   initial begin
      forever #2.5 clk = ~clk;
   end
   word_inc_dec_unit word_inc_dec_unit_inst (.core_clk_in(clk), .rst_in(rst), .req_in(req),
      .rsp_out(rsp));
   operand_store operand_store_inst (.core_clk_in(clk), .rst_in(rst), .go_in(go),
      .cond_in(cond), .op_in(op), .load_in(load), .load_val_in(load_val), .rsp_in(rsp),
      .req_out(req), .regs_out(regs), .seen_out(seen));
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // ----------------------------------------
   // one instruction through the sequencer
   // ----------------------------------------
   task automatic run(input string nm, input logic c, input word_inc_dec_pkg::op_t o,
         input logic [31:0] ini, input logic [31:0] exp, input logic ec);
      @(negedge clk);
      load = 1'b1;
      load_val = ini;
      @(negedge clk);
      load = 1'b0;
      go = 1'b1;
      cond = c;
      op = o;
      @(negedge clk);
      go = 1'b0;
      @(negedge clk);
      checks_done++;
      if (regs !== exp || seen !== ec) begin
         err_total++;
         $display("MISMATCH %0t %s pair %h out %b", $time, nm, regs, seen);
      end
      $display("test %s done", nm);
   endtask : run
   initial begin
      #100000;
      err_total++;
      summarize();
   end
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      run("dinc", 1, word_inc_dec_pkg::OP_DINC, 32'h075B_CD15, 32'h075B_CD16, 1);
      run("carry", 1, word_inc_dec_pkg::OP_DINC, 32'h0000_FFFF, 32'h0001_0000, 1);
      run("dwrap", 1, word_inc_dec_pkg::OP_DINC, 32'hFFFF_FFFF, 32'h0000_0000, 1);
      run("dsign", 1, word_inc_dec_pkg::OP_DINC, 32'h7FFF_FFFF, 32'h8000_0000, 1);
      run("dec", 1, word_inc_dec_pkg::OP_DEC, 32'hA5A5_0E51, 32'hA5A5_0E50, 1);
      run("decwrap", 1, word_inc_dec_pkg::OP_DEC, 32'h1234_0000, 32'h1234_FFFF, 1);
      run("decsign", 1, word_inc_dec_pkg::OP_DEC, 32'h0001_8000, 32'h0001_7FFF, 1);
      run("doff", 0, word_inc_dec_pkg::OP_DINC, 32'h1234_5678, 32'h1234_5678, 0);
      run("decoff", 0, word_inc_dec_pkg::OP_DEC, 32'h0000_0000, 32'h0000_0000, 0);
      run("noop", 1, word_inc_dec_pkg::OP_NONE, 32'h0000_0007, 32'h0000_0007, 0);
      summarize();
   end
endmodule : word_inc_dec_unit_tb_top
`default_nettype wire
